// File: core/tcs_timer_ctrl.sv
// Purpose: Start/stop triggers, enable status, input select, output control
// Assumes: Register port on the same clock; one-cycle interrupt pulses
// Notes: Counting itself lives in the channel counters outside this block

`timescale 1ns/1ps

module tcs_timer_ctrl
  import tcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [19:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrLow,
  input wire logic busWrHigh,
  input wire logic busRdEn,
  output logic [15:0] busRdData,
  output logic busRdValid,
  input wire logic splitCh1,
  input wire logic splitCh3,
  input wire logic [3:0] chanInterrupt,
  input wire logic tiPin0,
  input wire logic tiPin1,
  input wire logic eventLinkerCh0,
  input wire logic eventLinkerCh1,
  input wire logic lowSpeedOscClock,
  input wire logic subClock,
  output logic chanInput0,
  output logic chanInput1,
  output logic [3:0] chanStartPulse,
  output logic [3:0] chanStopPulse,
  output logic upperStartCh1,
  output logic upperStartCh3,
  output logic upperStopCh1,
  output logic upperStopCh3,
  output logic [3:0] chanEnableStatus,
  output logic upperEnableCh1,
  output logic upperEnableCh3,
  output logic [3:0] timerOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into an old register value
  function automatic logic [15:0] mergeBytes(
    input logic [15:0] oldVal,
    input logic [15:0] newVal,
    input logic wrLow,
    input logic wrHigh
  );
    logic [15:0] result;
    result = oldVal;
    if (wrLow) begin
      result[7:0] = newVal[7:0];
    end
    if (wrHigh) begin
      result[15:8] = newVal[15:8];
    end
    return result;
  endfunction : mergeBytes

  // Address match for a 16-bit register, either byte of it
  function automatic logic hitReg(
    input logic [19:0] addr,
    input logic [19:0] base
  );
    return addr[19:1] == base[19:1];
  endfunction : hitReg

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic anyWrite;
  logic wrStart;
  logic wrStop;
  logic wrInputSel;
  logic wrOutValue;
  logic wrOutEnable;
  logic wrOutPolarity;
  logic wrOutMode;
  logic [15:0] startTrig_reg;
  logic [15:0] startTrig_next;
  logic [15:0] stopTrig_reg;
  logic [15:0] stopTrig_next;
  logic [15:0] enable_reg;
  logic [15:0] enable_next;
  logic [15:0] splitMask;
  logic [15:0] startWrBits;
  logic [15:0] stopWrBits;
  logic [7:0] inputSel_reg;
  logic [15:0] outEnable_reg;
  logic [15:0] outPolarity_reg;
  logic [15:0] outMode_reg;
  logic [15:0] outValueWr;
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic [3:0] masterIrq;
  logic [15:0] rdMux;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  assign anyWrite = busWrLow | busWrHigh;
  assign wrStart = anyWrite & hitReg(busAddr, TCS_ADDR_START);
  assign wrStop = anyWrite & hitReg(busAddr, TCS_ADDR_STOP);
  assign wrInputSel = busWrLow & (busAddr == TCS_ADDR_INPUT_SEL);
  assign wrOutValue = anyWrite & hitReg(busAddr, TCS_ADDR_OUT_VALUE);
  assign wrOutEnable = anyWrite & hitReg(busAddr, TCS_ADDR_OUT_ENABLE);
  assign wrOutPolarity = anyWrite & hitReg(busAddr, TCS_ADDR_OUT_POLARITY);
  assign wrOutMode = anyWrite & hitReg(busAddr, TCS_ADDR_OUT_MODE);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger capture

  // Upper-half triggers only count while the channel is split
  always_comb begin
    splitMask = TCS_MASK_TRIGGER;
    splitMask[TCS_BIT_UPPER_CH1] = splitCh1; // [RL2] [RL7]
    splitMask[TCS_BIT_UPPER_CH3] = splitCh3; // [RL2] [RL7]
  end

  // Only ones are taken: a zero in any position means no trigger
  assign startWrBits = wrStart
    ? mergeBytes(16'h0000, busWrData, busWrLow, busWrHigh) & splitMask
    : 16'h0000; // [RL1] [RL2]
  assign stopWrBits = wrStop
    ? mergeBytes(16'h0000, busWrData, busWrLow, busWrHigh) & splitMask
    : 16'h0000; // [RL6] [RL7]

  // Start triggers live one cycle, cleared as the enable takes them
  assign startTrig_next = startWrBits;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startTrig_reg <= TCS_RST_REG16; // [RL22]
    end else begin
      startTrig_reg <= startTrig_next; // [RL1]
    end
  end

  // Stop trigger bits drop the cycle after the enable bit drops, so the
  // counter still sees one stop strobe
  assign stopTrig_next = stopWrBits | (stopTrig_reg & enable_reg); // [RL8]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stopTrig_reg <= TCS_RST_REG16; // [RL22]
    end else begin
      stopTrig_reg <= stopTrig_next; // [RL8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable status

  // Stop wins when start and stop land together, so a channel is
  // never left running by a conflicting write
  assign enable_next = (enable_reg | startTrig_reg) & ~stopTrig_reg; // [RL1] [RL6]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_reg <= TCS_RST_REG16; // [RL22]
    end else begin
      enable_reg <= enable_next; // [RL23]
    end
  end

  // Lower bits drive the lower half when split; upper bits separate
  assign chanEnableStatus = enable_reg[3:0]; // [RL3] [RL23]
  assign upperEnableCh1 = enable_reg[TCS_BIT_UPPER_CH1]; // [RL2] [RL23]
  assign upperEnableCh3 = enable_reg[TCS_BIT_UPPER_CH3]; // [RL2] [RL23]

  // Counter start and stop strobes, one cycle each
  assign chanStartPulse = startTrig_reg[3:0]; // [RL1] [RL3]
  assign chanStopPulse = stopTrig_reg[3:0] & ~enable_reg[3:0]; // [RL6] [RL3]
  assign upperStartCh1 = startTrig_reg[TCS_BIT_UPPER_CH1]; // [RL2]
  assign upperStartCh3 = startTrig_reg[TCS_BIT_UPPER_CH3]; // [RL2]
  assign upperStopCh1 = stopTrig_reg[TCS_BIT_UPPER_CH1]
    & ~enable_reg[TCS_BIT_UPPER_CH1]; // [RL7]
  assign upperStopCh3 = stopTrig_reg[TCS_BIT_UPPER_CH3]
    & ~enable_reg[TCS_BIT_UPPER_CH3]; // [RL7]

  ////////////////////////////////////////////////////////////////////////////
  // Input source select

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inputSel_reg <= TCS_RST_INPUT_SEL;
    end else if (wrInputSel) begin
      inputSel_reg <= busWrData[7:0] & TCS_MASK_INPUT_SEL;
    end
  end

  // Pins and foreign clocks pass two flops before any selection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
    end else begin
      syncA_reg <= {subClock, lowSpeedOscClock, tiPin1, tiPin0};
      syncB_reg <= syncA_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chanInput0 <= 1'b0;
    end else if (inputSel_reg[TCS_BIT_CH0_SOURCE]) begin
      chanInput0 <= eventLinkerCh0; // [RL10]
    end else begin
      chanInput0 <= syncB_reg[0]; // [RL10]
    end
  end

  // Prohibited codes give a quiet low input rather than a stray source
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chanInput1 <= 1'b0;
    end else begin
      case (inputSel_reg[2:0])
        TCS_SEL1_PIN_A: begin
          chanInput1 <= syncB_reg[1]; // [RL11]
        end
        TCS_SEL1_EVENT: begin
          chanInput1 <= eventLinkerCh1; // [RL11]
        end
        TCS_SEL1_PIN_B: begin
          chanInput1 <= syncB_reg[1]; // [RL11]
        end
        TCS_SEL1_LOSC: begin
          chanInput1 <= syncB_reg[2]; // [RL11]
        end
        TCS_SEL1_SUB: begin
          chanInput1 <= syncB_reg[3]; // [RL11]
        end
        default: begin
          chanInput1 <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output control registers

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outEnable_reg <= TCS_RST_REG16; // [RL22]
    end else if (wrOutEnable) begin
      outEnable_reg <= mergeBytes(outEnable_reg, busWrData,
        busWrLow, busWrHigh) & TCS_MASK_CHAN; // [RL22]
    end
  end

  // Channel 0 has no master above it, so its slave bits stay zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outPolarity_reg <= TCS_RST_REG16; // [RL22]
    end else if (wrOutPolarity) begin
      outPolarity_reg <= mergeBytes(outPolarity_reg, busWrData,
        busWrLow, busWrHigh) & TCS_MASK_SLAVE; // [RL22]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outMode_reg <= TCS_RST_REG16; // [RL22]
    end else if (wrOutMode) begin
      outMode_reg <= mergeBytes(outMode_reg, busWrData,
        busWrLow, busWrHigh) & TCS_MASK_SLAVE; // [RL22]
    end
  end

  assign outValueWr = mergeBytes({12'h000, timerOut}, busWrData,
    busWrLow, busWrHigh);

  ////////////////////////////////////////////////////////////////////////////
  // Output channels

  // Channel 3 follows channel 2 when 2 is a master, else channel 0
  always_comb begin
    masterIrq = 4'h0;
    masterIrq[1] = chanInterrupt[0]; // [RL18]
    masterIrq[2] = chanInterrupt[0]; // [RL18]
    masterIrq[3] = outMode_reg[2] ? chanInterrupt[0]
      : chanInterrupt[2]; // [RL18]
  end

  for (genvar ch = 0; ch < TCS_NUM_CHAN; ch++) begin : gOut
    tcs_out_chan uOut (
      .clock(clock),
      .rst(rst),
      .outEnable(outEnable_reg[ch]),
      .outMode(outMode_reg[ch]),
      .outPolarity(outPolarity_reg[ch]),
      .swWrite(wrOutValue), // [RL14]
      .swData(outValueWr[ch]),
      .ownIrq(chanInterrupt[ch]),
      .masterIrq(masterIrq[ch]),
      .outBit(timerOut[ch]) // [RL14]
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Trigger registers read zero; unmapped addresses read zero too
  always_comb begin
    rdMux = 16'h0000;
    if (busAddr == TCS_ADDR_INPUT_SEL) begin
      rdMux = {8'h00, inputSel_reg};
    end else if (hitReg(busAddr, TCS_ADDR_ENABLE_STATUS)) begin
      rdMux = enable_reg & TCS_MASK_TRIGGER; // [RL23]
    end else if (hitReg(busAddr, TCS_ADDR_START)) begin
      rdMux = 16'h0000; // [RL5]
    end else if (hitReg(busAddr, TCS_ADDR_STOP)) begin
      rdMux = 16'h0000; // [RL8]
    end else if (hitReg(busAddr, TCS_ADDR_OUT_VALUE)) begin
      rdMux = {12'h000, timerOut};
    end else if (hitReg(busAddr, TCS_ADDR_OUT_ENABLE)) begin
      rdMux = outEnable_reg;
    end else if (hitReg(busAddr, TCS_ADDR_OUT_POLARITY)) begin
      rdMux = outPolarity_reg;
    end else if (hitReg(busAddr, TCS_ADDR_OUT_MODE)) begin
      rdMux = outMode_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busRdData <= 16'h0000;
      busRdValid <= 1'b0;
    end else begin
      busRdValid <= busRdEn;
      if (busRdEn) begin
        busRdData <= rdMux;
      end
    end
  end

endmodule : tcs_timer_ctrl

// File: core/tcs_pkg.sv
// Purpose: Constants for the timer channel start/stop and output block
// Assumes: 16-bit registers at even byte addresses, byte-lane writes
// Notes: Shared by the control top and the output channel module
//
// Notes on behaviour
// RL1: Start bit 1 sets channel enable and allows counting; 0 does nothing.
// RL2: In split mode, upper start sets upper enable; upper half runs as interval.
// RL3: In split mode, ordinary start and stop bits act on lower half only.
// RL4: Software waits four or two clocks after mode change before starting.
// RL5: Start trigger register always reads zero.
// RL6: Stop bit 1 clears channel enable and halts counting; 0 does nothing.
// RL7: In split mode, upper stop clears upper enable and stops upper half.
// RL8: Stop bits self-clear once enable has cleared; register reads zero.
// RL9: Software writes zero to unused start and stop positions.
// RL10: Channel 0 source bit picks input pin at 0, linker event at 1.
// RL11: Channel 1 selector: pin, event, pin, -, low-speed osc, subclock.
// RL12: Selected input holds each level one clock plus 10 ns at least.
// RL13: Output enable 1 gives timer control, ignores writes; 0 freezes output.
// RL14: Output bit drives pin directly; writable only with output disabled.
// RL15: Software keeps output bit zero when pins serve as ports.
// RL16: Polarity applies only enabled in slave mode, at next set or reset.
// RL17: Polarity change while counting waits for next output change.
// RL18: Mode 0 toggles on own interrupt; mode 1 set by master, reset by slave.
// RL19: Output mode change takes effect at next set or reset only.
// RL20: Software writes zero to unused polarity and mode positions.
// RL21: Software writes zero to unused enable and value positions.
// RL22: All six registers reset to zero; low byte writable on its own.
// RL23: Enable status is read-only: bits 3..0 plus upper bits 11 and 9.

package tcs_pkg;

  localparam int TCS_NUM_CHAN = 4;

  // Byte addresses of the low byte of each register
  localparam logic [19:0] TCS_ADDR_INPUT_SEL = 20'hF0074;
  localparam logic [19:0] TCS_ADDR_ENABLE_STATUS = 20'hF01B0;
  localparam logic [19:0] TCS_ADDR_START = 20'hF01B2;
  localparam logic [19:0] TCS_ADDR_STOP = 20'hF01B4;
  localparam logic [19:0] TCS_ADDR_OUT_VALUE = 20'hF01B8;
  localparam logic [19:0] TCS_ADDR_OUT_ENABLE = 20'hF01BA;
  localparam logic [19:0] TCS_ADDR_OUT_POLARITY = 20'hF01BC;
  localparam logic [19:0] TCS_ADDR_OUT_MODE = 20'hF01BE;

  // Field positions
  localparam int TCS_BIT_UPPER_CH1 = 9;
  localparam int TCS_BIT_UPPER_CH3 = 11;
  localparam int TCS_BIT_CH0_SOURCE = 4;

  // Writable bit masks
  localparam logic [15:0] TCS_MASK_TRIGGER = 16'h0A0F;
  localparam logic [15:0] TCS_MASK_CHAN = 16'h000F;
  localparam logic [15:0] TCS_MASK_SLAVE = 16'h000E;
  localparam logic [7:0] TCS_MASK_INPUT_SEL = 8'h17;

  // Channel 1 source codes
  localparam logic [2:0] TCS_SEL1_PIN_A = 3'h0;
  localparam logic [2:0] TCS_SEL1_EVENT = 3'h1;
  localparam logic [2:0] TCS_SEL1_PIN_B = 3'h2;
  localparam logic [2:0] TCS_SEL1_LOSC = 3'h4;
  localparam logic [2:0] TCS_SEL1_SUB = 3'h5;

  // Reset values
  localparam logic [15:0] TCS_RST_REG16 = 16'h0000;
  localparam logic [7:0] TCS_RST_INPUT_SEL = 8'h00;

endpackage : tcs_pkg

// File: core/tcs_out_chan.sv
// Purpose: One channel's output bit with toggle and set/reset modes
// Assumes: Interrupt inputs are one-cycle pulses on the same clock
// Notes: Polarity and mode are sampled only at an output event

`timescale 1ns/1ps

module tcs_out_chan
  import tcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic outEnable,
  input wire logic outMode,
  input wire logic outPolarity,
  input wire logic swWrite,
  input wire logic swData,
  input wire logic ownIrq,
  input wire logic masterIrq,
  output logic outBit
);

  ////////////////////////////////////////////////////////////////////////////
  // Output bit

  // Mode and polarity are read only when an event lands, so a change in
  // between never moves the pin by itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outBit <= TCS_RST_REG16[0]; // [RL22]
    end else if (!outEnable) begin
      if (swWrite) begin
        outBit <= swData; // [RL13] [RL14]
      end
    end else if (!outMode) begin
      if (ownIrq) begin
        outBit <= ~outBit; // [RL18]
      end
    end else begin
      // Reset wins over set when both interrupts coincide
      if (ownIrq) begin
        outBit <= outPolarity; // [RL16] [RL17] [RL18] [RL19]
      end else if (masterIrq) begin
        outBit <= ~outPolarity; // [RL16] [RL17] [RL18] [RL19]
      end
    end
  end

endmodule : tcs_out_chan

// File: test/tcs_timer_ctrl_monitor.sv
// Purpose: Port-level checks for the timer channel control block
// Assumes: One clock, asynchronous active-high reset
// Notes: Channels 0 and 1 stand in for the others to keep checks short; the upper half of channel 3 has its own checks
`timescale 1ns/1ps
module tcs_timer_ctrl_monitor
  import tcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [19:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrLow,
  input wire logic busWrHigh,
  input wire logic busRdEn,
  input wire logic [15:0] busRdData,
  input wire logic busRdValid,
  input wire logic splitCh1,
  input wire logic [3:0] chanInterrupt,
  input wire logic [3:0] chanStartPulse,
  input wire logic [3:0] chanStopPulse,
  input wire logic upperStartCh1,
  input wire logic [3:0] chanEnableStatus,
  input wire logic upperEnableCh1,
  input wire logic upperStartCh3,
  input wire logic upperStopCh1,
  input wire logic upperStopCh3,
  input wire logic upperEnableCh3,
  input wire logic [3:0] timerOut
);
  logic wrS;
  logic wrT;
  logic rdTrig;
  assign wrS = busWrLow && busAddr[19:1] == TCS_ADDR_START[19:1];
  assign wrT = busWrLow && busAddr[19:1] == TCS_ADDR_STOP[19:1];
  assign rdTrig = busRdEn && (busAddr[19:1] == TCS_ADDR_START[19:1] ||
    busAddr[19:1] == TCS_ADDR_STOP[19:1]);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence stopCh0;
    chanEnableStatus[0] ##1 !chanEnableStatus[0] && chanStopPulse[0]
      ##1 !chanStopPulse[0];
  endsequence
  sequence upStart;
    upperStartCh1 ##1 upperEnableCh1;
  endsequence
  AST_START_PULSE:
    assert property (wrS |=> chanStartPulse == $past(busWrData[3:0]))
    else $error("start pulse differs from written bits");
  AST_ENABLE_SET:
    assert property (chanStartPulse[0] |=> chanEnableStatus[0])
    else $error("enable not set after start");
  AST_STOP_SEQ:
    assert property (wrT && busWrData[0] && chanEnableStatus[0] |=> stopCh0)
    else $error("stop sequence wrong");
  AST_READ_ZERO:
    assert property (rdTrig |=> busRdValid && busRdData == 16'h0000)
    else $error("trigger register read not zero");
  AST_UPPER_START:
    assert property (wrS && busWrHigh && busWrData[9] && splitCh1 |=> upStart)
    else $error("upper start failed");
  AST_SPLIT_LOWER:
    assert property (wrS && busWrData[1] && !(busWrHigh && busWrData[9])
      |=> !upperStartCh1)
    else $error("lower start hit upper half");
  AST_UPPER_STOP:
    assert property (wrT && busWrHigh && busWrData[9] && splitCh1 &&
      upperEnableCh1 |=> ##1 !upperEnableCh1)
    else $error("upper stop failed");
  AST_UPPER_STOP_PULSE:
    assert property ($fell(upperEnableCh1) |-> upperStopCh1 ##1 !upperStopCh1)
    else $error("upper stop strobe wrong");
  AST_UPPER3_START:
    assert property ($rose(upperEnableCh3) |-> $past(upperStartCh3))
    else $error("upper enable ch3 set without start");
  AST_UPPER3_STOP:
    assert property ($fell(upperEnableCh3) |-> upperStopCh3 ##1 !upperStopCh3)
    else $error("upper stop strobe ch3 wrong");
  // Pin may move only after an interrupt or a bus write
  AST_OUT_CAUSE:
    assert property ($changed(timerOut) |->
      $past(chanInterrupt) != 4'h0 || $past(busWrLow))
    else $error("output moved without cause");
endmodule : tcs_timer_ctrl_monitor

bind tcs_timer_ctrl tcs_timer_ctrl_monitor i_tcs_timer_ctrl_monitor (
  .clock, .rst, .busAddr, .busWrData, .busWrLow, .busWrHigh, .busRdEn,
  .busRdData, .busRdValid, .splitCh1, .chanInterrupt, .chanStartPulse,
  .chanStopPulse, .upperStartCh1, .chanEnableStatus, .upperEnableCh1,
  .upperStartCh3, .upperStopCh1, .upperStopCh3, .upperEnableCh3,
  .timerOut
);

// File: test/test_tcs_timer_ctrl.sv
// Purpose: Self-checking bench for the timer channel control block
// Assumes: Inputs change on the falling clock edge
// Notes: Counters are not modelled; interrupts are driven by hand
`timescale 1ns/1ps
module test_tcs_timer_ctrl
  import tcs_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [19:0] busAddr = 20'h00000;
  logic [15:0] busWrData = 16'h0000;
  logic busWrLow = 1'b0;
  logic busWrHigh = 1'b0;
  logic busRdEn = 1'b0;
  logic [15:0] busRdData;
  logic busRdValid;
  logic splitCh1 = 1'b0;
  logic splitCh3 = 1'b0;
  logic [3:0] chanInterrupt = 4'h0;
  logic tiPin0 = 1'b1;
  logic tiPin1 = 1'b1;
  logic eventLinkerCh0 = 1'b0;
  logic eventLinkerCh1 = 1'b0;
  logic lowSpeedOscClock = 1'b0;
  logic subClock = 1'b1;
  logic chanInput0, chanInput1, upperStartCh1, upperStartCh3;
  logic upperStopCh1, upperStopCh3, upperEnableCh1, upperEnableCh3;
  logic [3:0] chanStartPulse, chanStopPulse, chanEnableStatus, timerOut;
  int mismatches = 0;
  int testsRun = 0;
  logic [19:0] addrs [9] = '{TCS_ADDR_INPUT_SEL, TCS_ADDR_ENABLE_STATUS,
    TCS_ADDR_START, TCS_ADDR_STOP, TCS_ADDR_OUT_VALUE, TCS_ADDR_OUT_ENABLE,
    TCS_ADDR_OUT_POLARITY, TCS_ADDR_OUT_MODE, 20'hF01C0};
  // Last code is prohibited and must give a quiet input
  logic [7:0] selCode [6] = '{8'h00, 8'h11, 8'h02, 8'h14, 8'h15, 8'h13};
  logic [15:0] selExp [12] = '{16'h3, 16'h0, 16'h3, 16'h0, 16'h2, 16'h0,
    16'h0, 16'h3, 16'h0, 16'h3, 16'h1, 16'h1};

  tcs_timer_ctrl i_tcs_timer_ctrl (
    .clock, .rst, .busAddr, .busWrData, .busWrLow, .busWrHigh, .busRdEn,
    .busRdData, .busRdValid, .splitCh1, .splitCh3, .chanInterrupt, .tiPin0,
    .tiPin1, .eventLinkerCh0, .eventLinkerCh1, .lowSpeedOscClock, .subClock,
    .chanInput0, .chanInput1, .chanStartPulse, .chanStopPulse,
    .upperStartCh1, .upperStartCh3, .upperStopCh1, .upperStopCh3,
    .chanEnableStatus, .upperEnableCh1, .upperEnableCh3, .timerOut
  );

  always #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic wr(input logic [19:0] a, input logic [15:0] d,
    input logic hi);
    @(negedge clock);
    busAddr = a;
    busWrData = d;
    busWrLow = 1'b1;
    busWrHigh = hi;
    @(negedge clock);
    busWrLow = 1'b0;
    busWrHigh = 1'b0;
  endtask : wr

  // Data is registered, so it is settled at the next falling edge
  task automatic rdc(input logic [19:0] a, input logic [15:0] exp);
    @(negedge clock);
    busAddr = a;
    busRdEn = 1'b1;
    @(negedge clock);
    busRdEn = 1'b0;
    chk(busRdData, exp);
  endtask : rdc

  task automatic irq(input logic [3:0] m);
    @(negedge clock);
    chanInterrupt = m;
    @(negedge clock);
    chanInterrupt = 4'h0;
    tick(1);
  endtask : irq

  task automatic test_done;
    $display("mismatches %0d tests run %0d", mismatches, testsRun);
    if (mismatches == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    test_done();
  end

  initial begin
    tick(2);
    rst = 1'b0;
    foreach (addrs[i]) rdc(addrs[i], 16'h0000);
    wr(TCS_ADDR_START, 16'h000F, 1'b1);
    tick(2);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h000F);
    wr(TCS_ADDR_START, 16'h0000, 1'b1);
    wr(TCS_ADDR_ENABLE_STATUS, 16'hFFFF, 1'b1);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h000F);
    rdc(TCS_ADDR_START, 16'h0000);
    wr(TCS_ADDR_STOP, 16'h0005, 1'b1);
    tick(3);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h000A);
    rdc(TCS_ADDR_STOP, 16'h0000);
    splitCh1 = 1'b1;
    tick(4);
    wr(TCS_ADDR_START, 16'h0A00, 1'b1);
    tick(2);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h020A);
    wr(TCS_ADDR_STOP, 16'h0002, 1'b0);
    tick(3);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h0208);
    wr(TCS_ADDR_STOP, 16'h0200, 1'b1);
    tick(3);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h0008);
    // Upper start of channel 3 must be ignored until it is split
    wr(TCS_ADDR_START, 16'h0800, 1'b1);
    tick(2);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h0008);
    splitCh3 = 1'b1;
    tick(4);
    wr(TCS_ADDR_START, 16'h0800, 1'b1);
    tick(2);
    chk({15'h0000, upperEnableCh3}, 16'h0001);
    wr(TCS_ADDR_STOP, 16'h0800, 1'b1);
    tick(3);
    rdc(TCS_ADDR_ENABLE_STATUS, 16'h0008);
    wr(TCS_ADDR_OUT_VALUE, 16'h0005, 1'b1);
    rdc(TCS_ADDR_OUT_VALUE, 16'h0005);
    chk({12'h000, timerOut}, 16'h0005);
    wr(TCS_ADDR_OUT_ENABLE, 16'h0001, 1'b0);
    wr(TCS_ADDR_OUT_VALUE, 16'h000A, 1'b0);
    rdc(TCS_ADDR_OUT_VALUE, 16'h000B);
    irq(4'h1);
    chk({12'h000, timerOut}, 16'h000A);
    wr(TCS_ADDR_OUT_ENABLE, 16'h0003, 1'b0);
    wr(TCS_ADDR_OUT_MODE, 16'h0002, 1'b0);
    irq(4'h2);
    chk({12'h000, timerOut}, 16'h0008);
    irq(4'h1);
    chk({12'h000, timerOut}, 16'h000B);
    wr(TCS_ADDR_OUT_POLARITY, 16'h0002, 1'b0);
    chk({12'h000, timerOut}, 16'h000B);
    irq(4'h1);
    chk({12'h000, timerOut}, 16'h0008);
    irq(4'h2);
    chk({12'h000, timerOut}, 16'h000A);
    wr(TCS_ADDR_OUT_POLARITY, 16'h000E, 1'b1);
    rdc(TCS_ADDR_OUT_POLARITY, 16'h000E);
    wr(TCS_ADDR_OUT_MODE, 16'h000E, 1'b0);
    rdc(TCS_ADDR_OUT_MODE, 16'h000E);
    chk({12'h000, timerOut}, 16'h000A);
    // Second pass inverts every source so a stuck select is seen
    for (int j = 0; j < 2; j++) begin
      tiPin0 = (j == 0);
      tiPin1 = (j == 0);
      eventLinkerCh0 = (j == 1);
      eventLinkerCh1 = (j == 1);
      lowSpeedOscClock = (j == 1);
      subClock = (j == 0);
      for (int i = 0; i < 6; i++) begin
        wr(TCS_ADDR_INPUT_SEL, {8'h00, selCode[i]}, 1'b0);
        tick(4);
        chk({14'h0, chanInput1, chanInput0}, selExp[j * 6 + i]);
      end
    end
    wr(TCS_ADDR_INPUT_SEL, 16'h00FF, 1'b0);
    rdc(TCS_ADDR_INPUT_SEL, 16'h0017);
    // Pins handed back to the port function must idle low
    wr(TCS_ADDR_OUT_ENABLE, 16'h0000, 1'b0);
    wr(TCS_ADDR_OUT_VALUE, 16'h0000, 1'b0);
    chk({12'h000, timerOut}, 16'h0000);
    test_done();
  end
endmodule : test_tcs_timer_ctrl
